// ==== pkg/spm_pkg.sv ====
// Constants and state types for the service processor command mailbox.
// Assumes a 16-bit host word and a 16-bit wide memory with 32-bit addresses.
package spm_pkg;
	localparam logic [5:0]  SPM_DEV_CODE   = 6'h25;
	localparam int          FW_EN          = 15;
	localparam logic [6:0]  CMD_NOOP       = 7'h00;
	localparam logic [6:0]  CMD_SET_TIME   = 7'h01;
	localparam logic [6:0]  CMD_PD_SEL     = 7'h02;
	localparam logic [6:0]  CMD_PD_DIS     = 7'h03;
	localparam logic [6:0]  CMD_SET_BLOCK  = 7'h04;
	localparam logic [6:0]  CMD_ECC_ALL    = 7'h05;
	localparam logic [6:0]  CMD_ECC_PAGE   = 7'h06;
	localparam logic [6:0]  CMD_ECC_SOFT   = 7'h07;
	localparam logic [6:0]  CMD_ECC_SNIFF  = 7'h08;
	localparam logic [6:0]  CMD_ECC_OFF    = 7'h09;
	localparam logic [6:0]  CMD_SIZE       = 7'h0a;
	localparam logic [6:0]  CMD_SET_BOOT   = 7'h0b;
	localparam logic [6:0]  CMD_GET_BOOT   = 7'h0c;
	localparam logic [6:0]  CMD_SET_GMT    = 7'h0d;
	localparam logic [6:0]  CMD_GET_GMT    = 7'h0e;
	localparam logic [6:0]  CMD_DIAG       = 7'h7f;
	localparam logic [15:0] ST_LOG         = 16'h0000;
	localparam logic [15:0] ST_ACK         = 16'h0002;
	localparam logic [15:0] ST_FAIL        = 16'h0003;
	localparam logic [15:0] ST_DATA        = 16'h0004;
	localparam logic [15:0] SUB_BOOT       = 16'h0001;
	localparam logic [15:0] SUB_GMT        = 16'h0002;
	localparam logic [15:0] SIZE_ID        = 16'h005f;
	localparam logic [7:0]  BLK_ERR_OFS    = 8'h00;
	localparam logic [7:0]  BLK_IN_OFS     = 8'h02;
	localparam logic [3:0]  CLK_TIME_BASE  = 4'h0;
	localparam logic [3:0]  CLK_BOOT_BASE  = 4'h2;
	localparam logic [3:0]  CLK_GMT_BASE   = 4'h8;
	localparam logic [3:0]  ERR_LAST_WORD  = 4'hf;
	localparam logic [2:0]  ERR_NONE       = 3'h0;
	localparam logic [2:0]  ERR_SINGLE     = 3'h1;
	localparam logic [2:0]  ERR_SSNIFF     = 3'h3;
	localparam logic [7:0]  RST_BLOCK      = 8'h00;

	typedef enum logic [2:0] {S_IDLE, S_DECODE, S_PTR, S_XFER_RD, S_XFER_WR, S_CLR_IN, S_POST, S_ERR_WR} spm_state_t;

	typedef struct packed {
		spm_state_t        state;
		logic [15:0]       mailbox;
		logic [15:0]       fnWord;
		logic              cmdPending;
		logic              errEnable;
		logic              eccReportOn;
		logic              eccDetectOn;
		logic              maskSoft;
		logic              maskSniff;
		logic              pageMaskOn;
		logic [15:0]       maskPage;
		logic              powerdown;
		logic              diagMode;
		logic              echoRun;
		logic [7:0]        blockAddr;
		logic [1:0]        ptrIdx;
		logic [31:0]       inBase;
		logic [31:0]       outBase;
		logic [31:0]       errBase;
		logic [3:0]        idx;
		logic [15:0]       hold;
		logic [15:0][15:0] clockMem;
		logic              memReq;
		logic              memWe;
		logic [31:0]       memAddr;
		logic [15:0]       memWdata;
		logic              errPending;
		logic              errMode;
		logic [15:0]       errCodeHeld;
		logic [15:0]       postStatus;
	} spm_main_t;

	typedef struct packed {
		logic busy;
		logic done;
	} spm_flags_t;

	function automatic logic [31:0] spm_addr(input logic [31:0] base, input logic [7:0] ofs);
		return base + {24'h000000, ofs};
	endfunction
endpackage

// ==== hw/spm_cmd_decode.sv ====
// Command decoder: maps a function word to its buffer walk and completion status.
// Pure logic; the caller holds the function word stable while it reads the outputs.
module spm_cmd_decode
	import spm_pkg::*;
(
	input  logic [15:0] fnWord,
	input  logic        diagEcho,
	output logic        known,
	output logic        rdEn,
	output logic        wrEn,
	output logic        keep,
	output logic        usesIn,
	output logic [3:0]  first,
	output logic [3:0]  last,
	output logic [3:0]  memBase,
	output logic [15:0] word0,
	output logic [15:0] okStatus
);
	always_comb
	begin
		known = 1'b1;
		rdEn = 1'b0;
		wrEn = 1'b0;
		keep = 1'b0;
		usesIn = 1'b0;
		first = 4'h0;
		last = 4'h0;
		memBase = CLK_TIME_BASE;
		word0 = 16'h0000;
		okStatus = ST_ACK;
		if (diagEcho)
		begin
			rdEn = 1'b1;
			wrEn = 1'b1;
			last = 4'h7;
			word0 = fnWord;
			okStatus = ST_LOG;
		end
		else
		begin
			case (fnWord[14:8])
				CMD_NOOP, CMD_PD_SEL, CMD_PD_DIS, CMD_SET_BLOCK, CMD_ECC_SOFT, CMD_ECC_SNIFF, CMD_ECC_OFF, CMD_DIAG:
					known = 1'b1;
				CMD_SET_TIME:
				begin
					rdEn = 1'b1;
					usesIn = 1'b1;
					keep = 1'b1;
					last = 4'h2;
				end
				CMD_ECC_ALL:
				begin
					rdEn = 1'b1;
					usesIn = 1'b1;
					last = 4'h4;
				end
				CMD_ECC_PAGE:
				begin
					rdEn = 1'b1;
					usesIn = 1'b1;
					first = 4'h1;
					last = 4'h1;
				end
				CMD_SIZE:
				begin
					known = !fnWord[FW_EN];
					wrEn = 1'b1;
					last = 4'h1;
					word0 = SIZE_ID;
					okStatus = ST_LOG;
				end
				CMD_SET_BOOT, CMD_SET_GMT:
				begin
					rdEn = 1'b1;
					usesIn = 1'b1;
					keep = 1'b1;
					first = 4'h1;
					last = (fnWord[14:8] == CMD_SET_BOOT) ? 4'h6 : 4'h7;
					memBase = (fnWord[14:8] == CMD_SET_BOOT) ? CLK_BOOT_BASE : CLK_GMT_BASE;
				end
				CMD_GET_BOOT, CMD_GET_GMT:
				begin
					wrEn = 1'b1;
					okStatus = ST_DATA;
					last = (fnWord[14:8] == CMD_GET_BOOT) ? 4'h6 : 4'h7;
					memBase = (fnWord[14:8] == CMD_GET_BOOT) ? CLK_BOOT_BASE : CLK_GMT_BASE;
					word0 = (fnWord[14:8] == CMD_GET_BOOT) ? SUB_BOOT : SUB_GMT;
				end
				default:
					known = 1'b0;
			endcase
		end
	end
endmodule

// ==== hw/spm_flags.sv ====
// Busy and Done flags of the mailbox; Done doubles as the interrupt request.
// Every set beats a clear landing in the same cycle.
module spm_flags
	import spm_pkg::*;
(
	input  logic sys_clk,
	input  logic rst,
	input  logic setBusy,
	input  logic clrBusy,
	input  logic setDone,
	input  logic clrDone,
	output logic busy,
	output logic done,
	output logic intReq
);
	spm_flags_t r;
	spm_flags_t next_r;

	always_comb
	begin
		next_r.busy = setBusy | (r.busy & ~clrBusy);
		next_r.done = setDone | (r.done & ~clrDone);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign busy = r.busy;
	assign done = r.done;
	assign intReq = r.done;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_cmd_sets_busy: assert property (setBusy && !setDone |=> busy && !done)
		else $error("issue did not set busy and clear done");
	chk_clear_both: assert property (clrBusy && clrDone && !setBusy && !setDone |=> !busy && !done)
		else $error("flag clear left a flag set");
	chk_done_irq: assert property (setDone |=> done && intReq)
		else $error("done did not raise the interrupt");
endmodule

// ==== hw/spm_mailbox.sv ====
// Service processor side of the host command mailbox: flags, command engine,
// shared-buffer walker and error block reporter.
// Assumes host I/O strobes are one-cycle pulses and memory answers with memAck.
//
// Summary of operation
// - Engine zeroes inbound word 0 once it has consumed the buffer, except after a diagnostic echo.
// - Issue copies the host word into the mailbox, sets Busy, clears Done.
// - Engine clears Busy when it takes the mailbox word.
// - Engine takes the mailbox only while Done is low.
// - Unperformable command ends with status 3; only the enable bit still loads error reporting.
// - An error-report interrupt to the host switches error reporting off; command completions load it from the enable bit.
// - Returned data goes to the outbound buffer from word 1; size returns its type word in outbound word 0.
// - Time and GMT reads put a sub-code in outbound word 0.
// - Status written, then Done set, raising the device 45 interrupt.
// - Function word top bit enables (1) or disables (0) error reporting.
// - Bits 17-23 select the command; 017-176 undefined, 177 diagnostic.
// - Bits 24-31 give a page-zero pointer, or the size type.
// - Error report writes code plus 15 status words via page-zero pointer.
// - No-op only updates logging enable and enables memory error reports.
// - Set time reads words 0-2 and clears word 0 afterwards.
// - Set block latches bits 24-31 as the interface block address.
// - Memory error reports off after reset until a no-op or enable-all command.
// - 006 masks one page, 007 soft errors, 010 sniff errors.
// - 011 turns memory error reporting and detection off.
// - Size needs enable bit 0 and completes with status 0.
// - Flag clear forces Busy and Done to 0.
// - Status read returns the mailbox and clears Busy and Done.
module spm_mailbox
	import spm_pkg::*;
(
	input  logic        sys_clk,
	input  logic        rst,
	input  logic [5:0]  ioDevCode,
	input  logic        ioCmdStrobe,
	input  logic [15:0] ioCmdWord,
	input  logic        ioStatusRead,
	input  logic        ioFlagClear,
	input  logic        ioSysReset,
	output logic [15:0] statusWord,
	output logic        busy,
	output logic        done,
	output logic        intReq,
	output logic        memReq,
	output logic        memWe,
	output logic [31:0] memAddr,
	output logic [15:0] memWdata,
	input  logic [15:0] memRdata,
	input  logic        memAck,
	input  logic        errValid,
	input  logic [2:0]  errClass,
	input  logic [15:0] errPage,
	input  logic [15:0] errCode,
	input  logic [15:0] errExtWord,
	output logic [3:0]  errExtIdx,
	output logic        errReportEnable,
	output logic        eccDetectEnable,
	output logic        powerdownSel
);
	spm_main_t   r;
	spm_main_t   next_r;
	logic        cmdHit;
	logic        rdHit;
	logic        clrHit;
	logic        take;
	logic        evPass;
	logic        decKnown;
	logic        decRdEn;
	logic        decWrEn;
	logic        decKeep;
	logic        decUsesIn;
	logic [3:0]  decFirst;
	logic [3:0]  decLast;
	logic [3:0]  decBase;
	logic [15:0] decWord0;
	logic [15:0] decOk;
	logic [3:0]  slot;
	logic        doRd;
	logic [15:0] wrData;

	assign cmdHit = ioCmdStrobe && (ioDevCode == SPM_DEV_CODE);
	assign rdHit = ioStatusRead && (ioDevCode == SPM_DEV_CODE);
	assign clrHit = ioFlagClear && (ioDevCode == SPM_DEV_CODE);
	assign take = (r.state == S_IDLE) && r.cmdPending && !done;
	assign slot = 4'(decBase + r.idx);
	assign doRd = decRdEn && !(decWrEn && (r.idx == 4'h0));
	assign wrData = (r.idx == 4'h0) ? decWord0 : (r.echoRun ? ~r.hold : r.clockMem[slot]);

	// Soft and sniff masks only filter memory error classes
	assign evPass = errValid && r.errEnable && ((errClass == ERR_NONE) || (r.eccReportOn
		&& !(r.maskSoft && (errClass == ERR_SINGLE)) && !(r.maskSniff && (errClass >= ERR_SSNIFF))
		&& !(r.pageMaskOn && (errPage == r.maskPage))));

	spm_cmd_decode u_dec (
		.fnWord   (r.fnWord),
		.diagEcho (r.echoRun),
		.known    (decKnown),
		.rdEn     (decRdEn),
		.wrEn     (decWrEn),
		.keep     (decKeep),
		.usesIn   (decUsesIn),
		.first    (decFirst),
		.last     (decLast),
		.memBase  (decBase),
		.word0    (decWord0),
		.okStatus (decOk)
	);

	spm_flags u_flags (
		.sys_clk (sys_clk),
		.rst     (rst),
		.setBusy (cmdHit),
		.clrBusy (take | rdHit | clrHit | ioSysReset),
		.setDone (r.state == S_POST),
		.clrDone (cmdHit | rdHit | clrHit | ioSysReset),
		.busy    (busy),
		.done    (done),
		.intReq  (intReq)
	);

	always_comb
	begin
		next_r = r;
		case (r.state)
			S_IDLE:
			begin
				if (take)
				begin
					next_r.cmdPending = 1'b0;
					next_r.fnWord = r.mailbox;
					next_r.echoRun = r.diagMode;
					next_r.diagMode = 1'b0;
					next_r.state = S_DECODE;
				end
				else if (r.errPending && !r.cmdPending && !done)
				begin
					next_r.errPending = 1'b0;
					next_r.errMode = 1'b1;
					next_r.ptrIdx = 2'h0;
					next_r.state = S_PTR;
				end
			end
			S_DECODE:
			begin
				next_r.postStatus = decOk;
				if (!decKnown)
				begin
					next_r.postStatus = ST_FAIL;
					next_r.state = S_POST;
				end
				else if (!r.echoRun && (r.fnWord[14:8] == CMD_DIAG))
				begin
					// Busy already dropped; no Done until the echo command
					next_r.diagMode = 1'b1;
					next_r.state = S_IDLE;
				end
				else
				begin
					if (!r.echoRun)
					begin
						case (r.fnWord[14:8])
							CMD_NOOP:
								next_r.eccReportOn = 1'b1;
							CMD_PD_SEL:
								next_r.powerdown = 1'b1;
							CMD_PD_DIS:
								next_r.powerdown = 1'b0;
							CMD_SET_BLOCK:
								next_r.blockAddr = r.fnWord[7:0];
							CMD_ECC_ALL:
							begin
								next_r.eccReportOn = 1'b1;
								next_r.eccDetectOn = 1'b1;
							end
							CMD_ECC_SOFT:
								next_r.maskSoft = 1'b1;
							CMD_ECC_SNIFF:
								next_r.maskSniff = 1'b1;
							CMD_ECC_OFF:
							begin
								next_r.eccReportOn = 1'b0;
								next_r.eccDetectOn = 1'b0;
							end
							default:
								next_r.powerdown = r.powerdown;
						endcase
					end
					next_r.ptrIdx = 2'h0;
					next_r.state = (decRdEn || decWrEn) ? S_PTR : S_POST;
				end
			end
			S_PTR:
			begin
				if (!r.memReq)
				begin
					next_r.memReq = 1'b1;
					next_r.memWe = 1'b0;
					next_r.memAddr = spm_addr({24'h000000, r.blockAddr},
						8'((r.errMode ? BLK_ERR_OFS : BLK_IN_OFS) + {6'h00, r.ptrIdx}));
				end
				else if (memAck)
				begin
					next_r.memReq = 1'b0;
					next_r.ptrIdx = 2'(r.ptrIdx + 2'h1);
					case ({r.errMode, r.ptrIdx})
						3'h0:
							next_r.inBase[31:16] = memRdata;
						3'h1:
							next_r.inBase[15:0] = memRdata;
						3'h2:
							next_r.outBase[31:16] = memRdata;
						3'h4:
							next_r.errBase[31:16] = memRdata;
						3'h5:
						begin
							next_r.errBase[15:0] = memRdata;
							next_r.idx = 4'h0;
							next_r.state = S_ERR_WR;
						end
						default:
						begin
							next_r.outBase[15:0] = memRdata;
							next_r.idx = decFirst;
							next_r.state = S_XFER_RD;
						end
					endcase
				end
			end
			S_XFER_RD:
			begin
				if (!doRd)
					next_r.state = S_XFER_WR;
				else if (!r.memReq)
				begin
					next_r.memReq = 1'b1;
					next_r.memWe = 1'b0;
					next_r.memAddr = spm_addr(r.inBase, {4'h0, r.idx});
				end
				else if (memAck)
				begin
					next_r.memReq = 1'b0;
					next_r.hold = memRdata;
					if (decKeep)
						next_r.clockMem[slot] = memRdata;
					if (!r.echoRun && (r.fnWord[14:8] == CMD_ECC_PAGE))
					begin
						next_r.maskPage = memRdata;
						next_r.pageMaskOn = 1'b1;
					end
					next_r.state = S_XFER_WR;
				end
			end
			S_XFER_WR:
			begin
				if (decWrEn && !r.memReq)
				begin
					next_r.memReq = 1'b1;
					next_r.memWe = 1'b1;
					next_r.memAddr = spm_addr(r.outBase, {4'h0, r.idx});
					next_r.memWdata = wrData;
				end
				else if (!decWrEn || memAck)
				begin
					next_r.memReq = 1'b0;
					next_r.memWe = 1'b0;
					next_r.idx = 4'(r.idx + 4'h1);
					if (r.idx == decLast)
						next_r.state = decUsesIn ? S_CLR_IN : S_POST;
					else
						next_r.state = S_XFER_RD;
				end
			end
			S_CLR_IN:
			begin
				if (!r.memReq)
				begin
					next_r.memReq = 1'b1;
					next_r.memWe = 1'b1;
					next_r.memAddr = r.inBase;
					next_r.memWdata = 16'h0000;
				end
				else if (memAck)
				begin
					next_r.memReq = 1'b0;
					next_r.memWe = 1'b0;
					next_r.state = S_POST;
				end
			end
			S_ERR_WR:
			begin
				if (!r.memReq)
				begin
					next_r.memReq = 1'b1;
					next_r.memWe = 1'b1;
					next_r.memAddr = spm_addr(r.errBase, {4'h0, r.idx});
					next_r.memWdata = (r.idx == 4'h0) ? r.errCodeHeld : errExtWord;
				end
				else if (memAck)
				begin
					next_r.memReq = 1'b0;
					next_r.memWe = 1'b0;
					next_r.idx = 4'(r.idx + 4'h1);
					if (r.idx == ERR_LAST_WORD)
					begin
						next_r.postStatus = ST_LOG;
						next_r.state = S_POST;
					end
				end
			end
			default:
			begin
				// Status then Done in the same edge; the flag block sees S_POST
				next_r.mailbox = r.postStatus;
				next_r.errEnable = r.errMode ? 1'b0 : r.fnWord[FW_EN];
				next_r.errMode = 1'b0;
				next_r.echoRun = 1'b0;
				next_r.state = S_IDLE;
			end
		endcase
		// Events during a running report are dropped, not queued
		if (evPass && !r.errMode && !next_r.errMode)
		begin
			next_r.errPending = 1'b1;
			next_r.errCodeHeld = errCode;
		end
		if (ioSysReset)
		begin
			next_r.errEnable = 1'b0;
			next_r.eccReportOn = 1'b0;
			next_r.diagMode = 1'b0;
		end
		// Host write beats a status write in the same cycle
		if (cmdHit)
		begin
			next_r.mailbox = ioCmdWord;
			next_r.cmdPending = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.state <= S_IDLE;
			r.blockAddr <= RST_BLOCK;
		end
		else
			r <= next_r;
	end

	assign statusWord = r.mailbox;
	assign memReq = r.memReq;
	assign memWe = r.memWe;
	assign memAddr = r.memAddr;
	assign memWdata = r.memWdata;
	assign errExtIdx = r.idx;
	assign errReportEnable = r.errEnable;
	assign eccDetectEnable = r.eccDetectOn;
	assign powerdownSel = r.powerdown;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_busy_release: assert property (take && !cmdHit |=> !busy)
		else $error("busy not cleared when command taken");
	chk_done_gate: assert property (r.state == S_IDLE && done |=> r.state == S_IDLE)
		else $error("engine left idle while done high");
	chk_fail_status: assert property (r.state == S_DECODE && !decKnown |=> r.state == S_POST ##1
		((statusWord == ST_FAIL) || $past(cmdHit)) && done)
		else $error("failed command did not post status 3");
	chk_in_release: assert property (r.state == S_CLR_IN && r.memReq |-> memWe && memWdata == 16'h0000
		&& memAddr == r.inBase)
		else $error("inbound word 0 not released");
	chk_word0_sub: assert property (r.state == S_XFER_WR && memReq && r.idx == 4'h0 && !r.echoRun
		&& r.fnWord[14:8] == CMD_GET_GMT |-> memWdata == SUB_GMT)
		else $error("wrong sub-code in outbound word 0");
	chk_report_off: assert property (r.state == S_POST && r.errMode |=> !errReportEnable && done)
		else $error("reporting left on after error interrupt");
	chk_ecc_off: assert property (r.state == S_DECODE && decKnown && !r.echoRun && r.fnWord[14:8] == CMD_ECC_OFF
		|=> !eccDetectEnable && !r.eccReportOn)
		else $error("memory error detection not disabled");
	chk_block_latch: assert property (r.state == S_DECODE && decKnown && !r.echoRun
		&& r.fnWord[14:8] == CMD_SET_BLOCK |=> r.blockAddr == $past(r.fnWord[7:0]))
		else $error("interface block address not latched");

	cov_fail: cover property (r.state == S_DECODE && !decKnown ##2 done);
	cov_diag_echo: cover property (r.state == S_POST && r.echoRun);
	cov_err_report: cover property (r.state == S_POST && r.errMode);
	cov_get_boot: cover property (r.state == S_POST && r.postStatus == ST_DATA);
endmodule

// ==== tb/spm_mem_model.sv ====
// Behavioural word memory on the far side of the mailbox engine's memory port.
// Assumes one access at a time; the bench preloads and inspects mem directly.
module spm_mem_model
(
	input  wire logic        sys_clk,
	input  wire logic        slow,
	input  wire logic        memReq,
	input  wire logic        memWe,
	input  wire logic [31:0] memAddr,
	input  wire logic [15:0] memWdata,
	output logic      [15:0] memRdata,
	output logic             memAck
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] mem [0:255];
	logic [2:0]  waitCnt;

	initial
	begin
		memAck = 1'b0;
		memRdata = 16'h0000;
		waitCnt = 3'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 16'h0000;
	end

	// Data lines toggle outside an answer so a stale word never passes as valid
	always @(posedge sys_clk)
	begin
		memAck <= 1'b0;
		memRdata <= ~memRdata;
		if (memReq && !memAck)
		begin
			if (slow && waitCnt != 3'h3)
				waitCnt <= waitCnt + 3'h1;
			else
			begin
				waitCnt <= 3'h0;
				memAck <= 1'b1;
				memRdata <= mem[memAddr[7:0]];
				if (memWe)
					mem[memAddr[7:0]] <= memWdata;
			end
		end
	end
endmodule

// ==== tb/spm_mailbox_tb.sv ====
// Self-checking bench for the command mailbox, host I/O side plus memory model.
// Assumes buffers and blocks live in the low 256 words of memory.
module spm_mailbox_tb
	import spm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int BLK = 'h10;
	localparam int INB = 'h40;
	localparam int OUTB = 'h60;
	localparam int ERRB = 'h80;

	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  ioDevCode = 6'h25;
	logic        ioCmdStrobe = 1'b0;
	logic [15:0] ioCmdWord = 16'h0000;
	logic        ioStatusRead = 1'b0;
	logic        ioFlagClear = 1'b0;
	logic        ioSysReset = 1'b0;
	logic        errValid = 1'b0;
	logic [2:0]  errClass = 3'h0;
	logic [15:0] errPage = 16'h0000;
	logic [15:0] errCode = 16'h0000;
	logic        slow = 1'b0;
	logic [15:0] statusWord, memWdata, memRdata, errExtWord;
	logic [31:0] memAddr;
	logic [3:0]  errExtIdx;
	logic        busy, done, intReq, memReq, memWe, memAck;
	logic        errReportEnable, eccDetectEnable, powerdownSel;
	int          failCount = 0;
	int          compares = 0;
	int          cycles = 0;

	assign errExtWord = {12'h0a0, errExtIdx};

	spm_mailbox u_spm_mailbox (.sys_clk(sys_clk), .rst(rst), .ioDevCode(ioDevCode), .ioCmdStrobe(ioCmdStrobe),
		.ioCmdWord(ioCmdWord), .ioStatusRead(ioStatusRead), .ioFlagClear(ioFlagClear), .ioSysReset(ioSysReset),
		.statusWord(statusWord), .busy(busy), .done(done), .intReq(intReq), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .errValid(errValid),
		.errClass(errClass), .errPage(errPage), .errCode(errCode), .errExtWord(errExtWord),
		.errExtIdx(errExtIdx), .errReportEnable(errReportEnable), .eccDetectEnable(eccDetectEnable),
		.powerdownSel(powerdownSel));

	spm_mem_model u_spm_mem_model (.sys_clk(sys_clk), .slow(slow), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));

	always #2.5 sys_clk = ~sys_clk;

	task automatic stopTest();
		$display("compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Far longer than the whole sequence needs
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failCount++;
			stopTest();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		compares++;
		if (seen !== exp)
		begin
			failCount++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	function automatic logic [15:0] fw(input logic en, input logic [6:0] cmd, input logic [7:0] ptr);
		return {en, cmd, ptr};
	endfunction

	task automatic issue(input logic [15:0] w);
		while (busy !== 1'b0)
			@(negedge sys_clk);
		@(posedge sys_clk);
		ioCmdStrobe <= 1'b1;
		ioCmdWord <= w;
		@(posedge sys_clk);
		ioCmdStrobe <= 1'b0;
		@(negedge sys_clk);
	endtask

	task automatic waitDone();
		int n;
		n = 0;
		while (done !== 1'b1 && n < 400)
		begin
			@(negedge sys_clk);
			n++;
		end
		check({15'h0, done}, 16'h0001, "done missing");
	endtask

	task automatic readStatus();
		@(posedge sys_clk);
		ioStatusRead <= 1'b1;
		@(posedge sys_clk);
		ioStatusRead <= 1'b0;
		@(negedge sys_clk);
		check({14'h0, busy, done}, 16'h0000, "flags after read");
	endtask

	task automatic run(input logic [15:0] w, input logic [15:0] st);
		issue(w);
		waitDone();
		check(statusWord, st, "status");
		readStatus();
	endtask

	task automatic testNoop();
		check({busy, done, intReq, errReportEnable, eccDetectEnable, powerdownSel}, 16'h0000, "reset");
		issue(fw(1'b1, CMD_NOOP, 8'h00));
		check({14'h0, busy, done}, 16'h0002, "issue flags");
		waitDone();
		check({14'h0, busy, intReq}, 16'h0001, "busy at done");
		check(statusWord, ST_ACK, "noop status");
		check({15'h0, errReportEnable}, 16'h0001, "enable bit");
		@(posedge sys_clk);
		ioFlagClear <= 1'b1;
		@(posedge sys_clk);
		ioFlagClear <= 1'b0;
		@(negedge sys_clk);
		check({14'h0, busy, done}, 16'h0000, "flag clear");
		ioDevCode <= 6'h24;
		issue(fw(1'b0, CMD_NOOP, 8'h00));
		check({15'h0, busy}, 16'h0000, "other device");
		ioDevCode <= 6'h25;
		$display("end noop");
	endtask

	task automatic testUndef();
		run(fw(1'b0, 7'h10, 8'h00), ST_FAIL);
		run(fw(1'b0, 7'h7e, 8'h00), ST_FAIL);
		run(fw(1'b0, CMD_PD_SEL, 8'h00), ST_ACK);
		check({15'h0, powerdownSel}, 16'h0001, "pd on");
		run(fw(1'b0, CMD_PD_DIS, 8'h00), ST_ACK);
		check({15'h0, powerdownSel}, 16'h0000, "pd off");
		$display("end codes");
	endtask

	task automatic testBuffers();
		run(fw(1'b0, CMD_SET_BLOCK, BLK[7:0]), ST_ACK);
		check(u_spm_mem_model.mem[INB], 16'h0000, "inbound busy");
		u_spm_mem_model.mem[INB] = 16'h2c1a;
		run(fw(1'b0, CMD_SET_TIME, BLK[7:0]), ST_ACK);
		check(u_spm_mem_model.mem[INB], 16'h0000, "time word0");
		slow <= 1'b1;
		u_spm_mem_model.mem[INB] = 16'h0001;
		for (int k = 1; k < 8; k++)
			u_spm_mem_model.mem[INB + k] = 16'h0100 + 16'(k);
		run(fw(1'b0, CMD_SET_GMT, BLK[7:0]), ST_ACK);
		check(u_spm_mem_model.mem[INB], 16'h0000, "gmt word0");
		run(fw(1'b0, CMD_GET_GMT, BLK[7:0]), ST_DATA);
		check(u_spm_mem_model.mem[OUTB], SUB_GMT, "gmt sub-code");
		for (int k = 1; k < 8; k++)
			check(u_spm_mem_model.mem[OUTB + k], 16'h0100 + 16'(k), "gmt data");
		u_spm_mem_model.mem[INB] = 16'h0001;
		run(fw(1'b0, CMD_SET_BOOT, BLK[7:0]), ST_ACK);
		check(u_spm_mem_model.mem[INB], 16'h0000, "boot word0");
		run(fw(1'b0, CMD_GET_BOOT, BLK[7:0]), ST_DATA);
		check(u_spm_mem_model.mem[OUTB], SUB_BOOT, "boot sub-code");
		check(u_spm_mem_model.mem[OUTB + 6], 16'h0106, "boot data");
		slow <= 1'b0;
		run(fw(1'b1, CMD_SIZE, 8'h01), ST_FAIL);
		run(fw(1'b0, CMD_SIZE, 8'h01), ST_LOG);
		check(u_spm_mem_model.mem[OUTB], SIZE_ID, "size word0");
		$display("end buffers");
	endtask

	// Inbound words 1-7 still hold the set-clock pattern here
	task automatic testDiag();
		issue(fw(1'b0, CMD_DIAG, BLK[7:0]));
		repeat (10) @(negedge sys_clk);
		check({14'h0, busy, done}, 16'h0000, "diag entry");
		run(16'h805a, ST_LOG);
		check(u_spm_mem_model.mem[OUTB], 16'h805a, "echo word0");
		for (int k = 1; k < 8; k++)
			check(u_spm_mem_model.mem[OUTB + k], ~(16'h0100 + 16'(k)), "echo data");
		$display("end diag");
	endtask

	task automatic testErrors();
		u_spm_mem_model.mem[INB] = 16'h0001;
		run(fw(1'b1, CMD_ECC_ALL, BLK[7:0]), ST_ACK);
		check({14'h0, eccDetectEnable, errReportEnable}, 16'h0003, "ecc on");
		@(posedge sys_clk);
		errValid <= 1'b1;
		errClass <= ERR_SINGLE;
		errCode <= 16'h002b;
		errPage <= 16'h0033;
		@(posedge sys_clk);
		errValid <= 1'b0;
		waitDone();
		check(statusWord, ST_LOG, "report status");
		check(u_spm_mem_model.mem[ERRB], 16'h002b, "error code");
		for (int k = 1; k < 16; k++)
			check(u_spm_mem_model.mem[ERRB + k], 16'ha00 + 16'(k), "ext status");
		check({15'h0, errReportEnable}, 16'h0000, "report off");
		readStatus();
		run(fw(1'b1, CMD_ECC_SOFT, BLK[7:0]), ST_ACK);
		@(posedge sys_clk);
		errValid <= 1'b1;
		@(posedge sys_clk);
		errValid <= 1'b0;
		// Long enough for a full unmasked report to have posted Done
		repeat (100) @(negedge sys_clk);
		check({14'h0, done, errReportEnable}, 16'h0001, "soft masked");
		@(posedge sys_clk);
		ioSysReset <= 1'b1;
		@(posedge sys_clk);
		ioSysReset <= 1'b0;
		@(negedge sys_clk);
		check({15'h0, errReportEnable}, 16'h0000, "io reset");
		run(fw(1'b0, CMD_ECC_OFF, BLK[7:0]), ST_ACK);
		check({15'h0, eccDetectEnable}, 16'h0000, "detect off");
		$display("end errors");
	endtask

	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		u_spm_mem_model.mem[BLK + 1] = 16'(ERRB);
		u_spm_mem_model.mem[BLK + 3] = 16'(INB);
		u_spm_mem_model.mem[BLK + 5] = 16'(OUTB);
		@(negedge sys_clk);
		testNoop();
		testUndef();
		testBuffers();
		testDiag();
		testErrors();
		stopTest();
	end
endmodule
